// file: rtl/pvs_pkg.sv
// Constants for the loop scale, output floor and switching rate commands
// Contract
// [R1] Every loop scale value in range is accepted, stored and read back unchanged.
// [R2] Decoded loop scale quantizes to divider 0.125, 0.25, 0.5 or 1.0.
// [R3] Out-of-range loop scale write is flagged invalid and the host notified.
// [R4] Reference scaling uses the programmed loop scale, not the quantized divider.
// [R5] Floor limit is 16-bit unsigned absolute; target never goes below it.
// [R6] Change below floor while converting warns and ramps to floor at rate.
// [R7] Warning sets none-of-above, word VOUT bit, output_floor_limit/max bit, notifies host.
// [R8] Conflicting maximum limit write gives the same clamp and warn response.
// [R9] Floor limit range equals maximum limit range; outside is invalid data.
// [R10] Switching rate command is kHz in 11-bit signed linear format.
// [R11] Scale and frequency reach hardware at once only when conversion is off.
// [R12] Frequency exponent field is regenerated at reset from the stored frequency.
// [R13] Scale, floor and frequency restore at power-up from NVM or pin strap.
// [R14] Decoded frequency maps onto twelve effective frequencies 225 to 1500 kHz.
// [R15] Output changes during conversion ramp at the programmed transition rate.
// [R16] Linear value is 11-bit signed mantissa times two to 5-bit signed exponent.
package pvs_pkg;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [7:0] CMD_LOOP_SCALE  = 8'h29;
	localparam logic [7:0] CMD_FLOOR_LIMIT = 8'h2b;
	localparam logic [7:0] CMD_SW_RATE     = 8'h33;

	// ************************************************************
	// Field layout
	// ************************************************************
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 11;
	localparam int MAN_MSB = 10;

	// ************************************************************
	// Reset values and limits
	// ************************************************************
	localparam logic [4:0]  LOOP_SCALE_EXP_RST = 5'h19;
	localparam logic [15:0] LOOP_SCALE_RST     = {LOOP_SCALE_EXP_RST, 11'h008};
	localparam logic [15:0] FLOOR_RST          = 16'h0000;
	localparam logic [15:0] SW_RATE_RST        = 16'h0000;
	localparam logic [15:0] VOUT_RANGE_MAX     = 16'hffff;
	// Scale in Q.16 fixed point; valid range 1/32 .. 1
	localparam logic [31:0] SCALE_Q_MIN  = 32'h0000_0800;
	localparam logic [31:0] SCALE_Q_MAX  = 32'h0001_0000;
	localparam logic [31:0] SCALE_Q_0125 = 32'h0000_2000;
	localparam logic [31:0] SCALE_Q_025  = 32'h0000_4000;
	localparam logic [31:0] SCALE_Q_05   = 32'h0000_8000;
	localparam int          Q_FRAC       = 16;
	localparam logic [31:0] FSW_MIN_KHZ  = 32'd200;
	localparam logic [31:0] FSW_MAX_KHZ  = 32'd1650;

	// ************************************************************
	// Divider codes and status bits
	// ************************************************************
	typedef enum logic [1:0] {
		DIV_0125 = 2'b00,
		DIV_025  = 2'b01,
		DIV_05   = 2'b11,
		DIV_1    = 2'b10
	} pvs_div_t;

	localparam int SB_NONE_ABOVE = 0;
	localparam int SW_VOUT_BIT   = 15;
	localparam int SV_MINMAX_BIT = 6;
	localparam int SC_INVALID    = 6;

	// Decode signed linear word into Q.16 magnitude (negative gives zero)
	function automatic logic [31:0] lin_to_q(input logic [15:0] w); // [R16]
		logic signed [4:0]  e;
		logic signed [10:0] m;
		logic [47:0]        acc;
		e = w[EXP_MSB:EXP_LSB];
		m = w[MAN_MSB:0];
		acc = 48'(m[10] ? 11'h000 : m) << Q_FRAC;
		if (e >= 0) acc = acc << e;
		else        acc = acc >> (-e);
		lin_to_q = (acc > 48'hffff_ffff) ? 32'hffff_ffff : acc[31:0];
	endfunction

endpackage

// file: rtl/pvs_regs.sv
// Command registers for loop scale, output floor and switching rate
`timescale 1ns/1ps
module pvs_regs import pvs_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Command port from the bus protocol engine
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata,
	output logic             cmd_rvalid,
	// Power-up restore from NVM or pin strap
	input  wire logic        restore,
	input  wire logic [15:0] nvm_loop_scale,
	input  wire logic [15:0] nvm_floor,
	input  wire logic [15:0] nvm_sw_rate,
	// Conversion state and voltage target requests
	input  wire logic        conv_en,
	input  wire logic        lockout_cycle,
	input  wire logic        target_req,
	input  wire logic [15:0] target_in,
	input  wire logic        max_wr,
	input  wire logic [15:0] max_in,
	input  wire logic [15:0] slew_step,
	// Status reporting
	input  wire logic        status_clr,
	output logic      [7:0]  status_byte,
	output logic      [15:0] status_word,
	output logic      [7:0]  status_vout,
	output logic      [7:0]  status_cml,
	output logic             host_alert,
	// Hardware settings
	output logic      [1:0]  divider_sel,
	output logic      [15:0] ref_scale,
	output logic      [3:0]  fsw_index,
	output logic      [15:0] vout_target
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic [15:0] scale_reg, scale_next;
	logic [15:0] floor_reg, floor_next;
	logic [15:0] rate_reg, rate_next;
	logic [1:0]  div_reg, div_next;
	logic [15:0] rsc_reg, rsc_next;
	logic [3:0]  fidx_reg, fidx_next;
	logic [15:0] tgt_reg, tgt_next;
	logic [15:0] goal_reg, goal_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        rval_reg, rval_next;
	logic        warn_reg, warn_next;
	logic        inval_reg, inval_next;
	logic        alert_reg, alert_next;

	// Quantize scale to divider code
	function automatic logic [1:0] quant(input logic [31:0] q); // [R2]
		if (q <= SCALE_Q_0125)     quant = DIV_0125;
		else if (q <= SCALE_Q_025) quant = DIV_025;
		else if (q <= SCALE_Q_05)  quant = DIV_05;
		else                       quant = DIV_1;
	endfunction

	// Effective frequency band of a decoded kHz value
	function automatic logic [3:0] fband(input logic [31:0] q); // [R14]
		logic [31:0] k;
		k = q >> Q_FRAC;
		if (k <= 32'd250)       fband = 4'd0;
		else if (k <= 32'd300)  fband = 4'd1;
		else if (k <= 32'd350)  fband = 4'd2;
		else if (k <= 32'd410)  fband = 4'd3;
		else if (k <= 32'd500)  fband = 4'd4;
		else if (k <= 32'd600)  fband = 4'd5;
		else if (k <= 32'd700)  fband = 4'd6;
		else if (k <= 32'd820)  fband = 4'd7;
		else if (k <= 32'd1000) fband = 4'd8;
		else if (k <= 32'd1200) fband = 4'd9;
		else if (k <= 32'd1400) fband = 4'd10;
		else                    fband = 4'd11;
	endfunction

	// Exponent chosen so the kHz figure fits a positive mantissa
	function automatic logic [15:0] fsw_norm(input logic [15:0] w); // [R12]
		logic [31:0] k;
		k = lin_to_q(w) >> Q_FRAC;
		if (k < 32'd1024) fsw_norm = {5'h00, k[10:0]};
		else              fsw_norm = {5'h01, k[11:1]};
	endfunction

	// Saturate Q.16 scale to the 16-bit reference word
	function automatic logic [15:0] q_sat16(input logic [31:0] q); // [R4]
		if (q > 32'h0000_ffff) q_sat16 = 16'hffff;
		else                   q_sat16 = q[15:0];
	endfunction

	// ************************************************************
	// Next-state logic
	// ************************************************************
	logic [31:0] wq;
	logic        scale_ok, floor_ok, rate_ok, below;
	always_comb begin
		wq         = lin_to_q(cmd_wdata);
		scale_ok   = (wq >= SCALE_Q_MIN) && (wq <= SCALE_Q_MAX) && !cmd_wdata[MAN_MSB];
		floor_ok   = (cmd_wdata <= VOUT_RANGE_MAX); // [R9]
		rate_ok    = (wq >= (FSW_MIN_KHZ << Q_FRAC)) && (wq <= (FSW_MAX_KHZ << Q_FRAC))
			&& !cmd_wdata[MAN_MSB]; // [R10]
		scale_next = scale_reg;
		floor_next = floor_reg;
		rate_next  = rate_reg;
		div_next   = div_reg;
		rsc_next   = rsc_reg;
		fidx_next  = fidx_reg;
		goal_next  = goal_reg;
		warn_next  = warn_reg && !status_clr;
		inval_next = inval_reg && !status_clr;
		alert_next = 1'b0;
		rdata_next = rdata_reg;
		rval_next  = 1'b0;
		below      = 1'b0;
		if (restore) begin // [R13]
			scale_next = nvm_loop_scale;
			floor_next = nvm_floor;
			rate_next  = fsw_norm(nvm_sw_rate); // [R12]
			div_next   = quant(lin_to_q(nvm_loop_scale));
			rsc_next   = q_sat16(lin_to_q(nvm_loop_scale));
			fidx_next  = fband(lin_to_q(nvm_sw_rate));
		end else if (cmd_wr) begin
			if (cmd_code == CMD_LOOP_SCALE) begin
				if (scale_ok) begin
					scale_next = cmd_wdata; // [R1]
					if (!conv_en) begin // [R11]
						div_next = quant(wq); // [R2]
						rsc_next = q_sat16(wq); // [R4]
					end
				end else begin
					inval_next = 1'b1; // [R3]
					alert_next = 1'b1;
				end
			end else if (cmd_code == CMD_FLOOR_LIMIT) begin
				if (floor_ok) floor_next = cmd_wdata; // [R5]
				else begin
					inval_next = 1'b1; // [R9]
					alert_next = 1'b1;
				end
			end else if (cmd_code == CMD_SW_RATE) begin
				if (rate_ok) begin
					rate_next = cmd_wdata;
					if (!conv_en) fidx_next = fband(wq); // [R11]
				end else begin
					inval_next = 1'b1;
					alert_next = 1'b1;
				end
			end else begin
				inval_next = 1'b1;
				alert_next = 1'b1;
			end
		end
		// Held writes reach hardware on the supply cycle, not during restore
		// Uses the next values so a write in the same cycle is not lost
		if (lockout_cycle && !restore) begin // [R11]
			div_next  = quant(lin_to_q(scale_next));
			rsc_next  = q_sat16(lin_to_q(scale_next));
			fidx_next = fband(lin_to_q(rate_next));
		end
		if (target_req) begin
			below = conv_en && (target_in < floor_reg); // [R6]
			goal_next = (target_in < floor_reg) ? floor_reg : target_in; // [R5]
		end
		if (max_wr && conv_en && (max_in < tgt_reg)) begin // [R8]
			below     = 1'b1;
			goal_next = (max_in < floor_reg) ? floor_reg : max_in;
		end
		if (goal_next < floor_next) goal_next = floor_next; // [R5]
		if (below) begin
			warn_next  = 1'b1; // [R7]
			alert_next = 1'b1;
		end
		// Ramp toward goal one slew step per cycle; jump when off
		if (!conv_en) tgt_next = goal_reg; // [R15]
		else if (tgt_reg < goal_reg)
			tgt_next = (goal_reg - tgt_reg > slew_step) ? tgt_reg + slew_step : goal_reg;
		else if (tgt_reg > goal_reg)
			tgt_next = (tgt_reg - goal_reg > slew_step) ? tgt_reg - slew_step : goal_reg;
		else tgt_next = tgt_reg;
		if (cmd_rd) begin
			rval_next = 1'b1;
			if (cmd_code == CMD_LOOP_SCALE)       rdata_next = scale_reg; // [R1]
			else if (cmd_code == CMD_FLOOR_LIMIT) rdata_next = floor_reg;
			else if (cmd_code == CMD_SW_RATE)     rdata_next = rate_reg;
			else                                  rdata_next = 16'h0000;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scale_reg <= LOOP_SCALE_RST;
			floor_reg <= FLOOR_RST;
			rate_reg  <= SW_RATE_RST;
			div_reg   <= DIV_1;
			rsc_reg   <= 16'h0000;
			fidx_reg  <= 4'h0;
			tgt_reg   <= FLOOR_RST;
			goal_reg  <= FLOOR_RST;
			rdata_reg <= 16'h0000;
			rval_reg  <= 1'b0;
			warn_reg  <= 1'b0;
			inval_reg <= 1'b0;
			alert_reg <= 1'b0;
		end else begin
			scale_reg <= scale_next;
			floor_reg <= floor_next;
			rate_reg  <= rate_next;
			div_reg   <= div_next;
			rsc_reg   <= rsc_next;
			fidx_reg  <= fidx_next;
			tgt_reg   <= tgt_next;
			goal_reg  <= goal_next;
			rdata_reg <= rdata_next;
			rval_reg  <= rval_next;
			warn_reg  <= warn_next;
			inval_reg <= inval_next;
			alert_reg <= alert_next;
		end
	end

	// Status words are pure bit placement of the sticky flags
	always_comb begin
		status_byte = 8'h00;
		status_word = 16'h0000;
		status_vout = 8'h00;
		status_cml  = 8'h00;
		status_byte[SB_NONE_ABOVE] = warn_reg; // [R7]
		status_word[SW_VOUT_BIT]   = warn_reg;
		status_vout[SV_MINMAX_BIT] = warn_reg;
		status_cml[SC_INVALID]     = inval_reg; // [R3]
		status_word[SB_NONE_ABOVE] = warn_reg;
	end
	assign cmd_rdata   = rdata_reg;
	assign cmd_rvalid  = rval_reg;
	assign host_alert  = alert_reg;
	assign divider_sel = div_reg;
	assign ref_scale   = rsc_reg;
	assign fsw_index   = fidx_reg;
	assign vout_target = tgt_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_low_req;
		target_req && conv_en && !restore && (target_in < floor_reg);
	endsequence

	AST_SCALE_STORED: assert property (cmd_wr && !restore && cmd_code == CMD_LOOP_SCALE && scale_ok |=> scale_reg == $past(cmd_wdata)) else $error("scale not stored"); // [R1]
	AST_DIV_QUANT: assert property (cmd_wr && !restore && !lockout_cycle && !conv_en && cmd_code == CMD_LOOP_SCALE && scale_ok && wq <= SCALE_Q_0125 |=> div_reg == DIV_0125) else $error("bad divider"); // [R2]
	AST_SCALE_INVALID: assert property (cmd_wr && !restore && cmd_code == CMD_LOOP_SCALE && !scale_ok |=> inval_reg && host_alert) else $error("invalid scale not flagged"); // [R3]
	AST_FLOOR_HELD: assert property (##1 !$past(restore) && !$past(target_req) && !$past(max_wr) |-> goal_reg >= $past(floor_reg) || floor_reg != $past(floor_reg)) else $error("goal below floor"); // [R5]
	AST_LOW_WARN: assert property (s_low_req |=> warn_reg && host_alert ##0 status_vout[SV_MINMAX_BIT] && status_byte[SB_NONE_ABOVE]) else $error("no min warning"); // [R6]
	AST_WORD_BIT: assert property (status_clr && !target_req && !max_wr |=> !status_word[SW_VOUT_BIT] && status_word[SB_NONE_ABOVE] == status_vout[SV_MINMAX_BIT]) else $error("status mismatch"); // [R7]
	AST_MAX_CONFLICT: assert property (max_wr && conv_en && !restore && max_in < tgt_reg |=> warn_reg) else $error("max conflict no warn"); // [R8]
	AST_BLOCKED: assert property (conv_en && !restore && !lockout_cycle |=> div_reg == $past(div_reg) && fsw_index == $past(fidx_reg)) else $error("update not blocked"); // [R11]
	AST_RESTORE: assert property (restore |=> floor_reg == $past(nvm_floor) && scale_reg == $past(nvm_loop_scale)) else $error("restore failed"); // [R13]
	AST_RAMP: assert property (conv_en && tgt_reg < goal_reg && goal_reg - tgt_reg > slew_step |=> vout_target == $past(tgt_reg) + $past(slew_step)) else $error("ramp step wrong"); // [R15]

endmodule // pvs_regs

// file: testbench/pvs_host.sv
// Host model issuing command reads and writes
`timescale 1ns/1ps
module pvs_host (
	// Clock
	input  wire logic        clk,
	// Command port
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [7:0]  cmd_code,
	output logic      [15:0] cmd_wdata,
	input  wire logic [15:0] cmd_rdata,
	input  wire logic        cmd_rvalid
);
	// ************************************************************
	// Word transfers, whole 16-bit linear or unsigned words
	// ************************************************************
	initial begin
		cmd_wr    = 1'b0;
		cmd_rd    = 1'b0;
		cmd_code  = 8'h00;
		cmd_wdata = 16'h0000;
	end

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd_wr    = 1'b1;
		cmd_code  = c;
		cmd_wdata = d;
		@(negedge clk);
		cmd_wr    = 1'b0;
		// Stale data inverted so a missed capture shows
		cmd_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge clk);
		cmd_rd   = 1'b1;
		cmd_code = c;
		@(negedge clk);
		cmd_rd = 1'b0;
		d      = 16'hxxxx;
		// Bounded wait, an absent answer stays unknown
		for (int i = 0; i < 4; i++) begin
			if (cmd_rvalid === 1'b1) begin
				d = cmd_rdata;
				break;
			end
			@(negedge clk);
		end
	endtask
endmodule // pvs_host

// file: testbench/pvs_regs_tb.sv
// Testbench for the loop scale, floor and switching rate commands
`timescale 1ns/1ps
module pvs_regs_tb import pvs_pkg::*; ;
	logic        clk = 1'b0, rst = 1'b1;
	logic        cmd_wr, cmd_rd, cmd_rvalid, host_alert;
	logic [7:0]  cmd_code, status_byte, status_vout, status_cml;
	logic [15:0] cmd_wdata, cmd_rdata, status_word, ref_scale, vout_target;
	logic        restore = 0, conv_en = 0, lockout_cycle = 0;
	logic        target_req = 0, max_wr = 0, status_clr = 0;
	logic [15:0] nvm_loop_scale = 16'he002, nvm_floor = 16'h0200;
	logic [15:0] nvm_sw_rate = 16'h0871, target_in = 0, max_in = 0;
	logic [15:0] slew_step = 16'h0100, rd_v, alert_cnt = 0;
	logic [1:0]  divider_sel;
	logic [3:0]  fsw_index;
	int          error_cnt = 0, comparisons = 0;
	localparam logic [15:0] SC_W [8] = '{16'hd801, 16'he002, 16'he003, 16'he004,
		16'he006, 16'he008, 16'he009, 16'he010};
	localparam logic [1:0]  SC_D [8] = '{2'b00, 2'b00, 2'b01, 2'b01,
		2'b11, 2'b11, 2'b10, 2'b10};
	localparam logic [15:0] SC_R [8] = '{16'h0800, 16'h2000, 16'h3000, 16'h4000,
		16'h6000, 16'h8000, 16'h9000, 16'hffff};
	localparam logic [15:0] F_W [3] = '{16'h00e1, 16'h0226, 16'h0aee};
	localparam logic [3:0]  F_I [3] = '{4'h0, 4'h5, 4'hb};

	always #4 clk = ~clk;
	always @(posedge clk) if (host_alert === 1'b1) alert_cnt <= alert_cnt + 16'h1;

	pvs_regs u_pvs_regs (.clk(clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid), .restore(restore), .nvm_loop_scale(nvm_loop_scale),
		.nvm_floor(nvm_floor), .nvm_sw_rate(nvm_sw_rate), .conv_en(conv_en),
		.lockout_cycle(lockout_cycle), .target_req(target_req), .target_in(target_in),
		.max_wr(max_wr), .max_in(max_in), .slew_step(slew_step),
		.status_clr(status_clr), .status_byte(status_byte), .status_word(status_word),
		.status_vout(status_vout), .status_cml(status_cml), .host_alert(host_alert),
		.divider_sel(divider_sel), .ref_scale(ref_scale), .fsw_index(fsw_index),
		.vout_target(vout_target));
	pvs_host u_pvs_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid));

	// ************************************************************
	// Checking and closing
	// ************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
		u_pvs_host.rd(c, rd_v);
		check(rd_v, exp);
	endtask

	// Run is about a hundred cycles; generous margin
	initial begin
		#20000;
		error_cnt++;
		end_sim;
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check({14'h0, divider_sel}, 16'h0002);
		rd_chk(CMD_LOOP_SCALE, LOOP_SCALE_RST);
		rd_chk(CMD_FLOOR_LIMIT, FLOOR_RST);
		// Quantize table, exact and in-between values
		for (int i = 0; i < 8; i++) begin
			u_pvs_host.wr(CMD_LOOP_SCALE, SC_W[i]);
			check({14'h0, divider_sel}, {14'h0, SC_D[i]});
			check(ref_scale, SC_R[i]);
			rd_chk(CMD_LOOP_SCALE, SC_W[i]);
		end
		// Above one, then negative mantissa: both refused
		u_pvs_host.wr(CMD_LOOP_SCALE, 16'he011);
		u_pvs_host.wr(CMD_LOOP_SCALE, 16'he7f8);
		rd_chk(CMD_LOOP_SCALE, 16'he010);
		check({15'h0, status_cml[6]}, 16'h0001);
		check(alert_cnt, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			u_pvs_host.wr(CMD_SW_RATE, F_W[i]);
			check({12'h0, fsw_index}, {12'h0, F_I[i]});
		end
		// Rate below range and an unknown command: both refused
		u_pvs_host.wr(CMD_SW_RATE, 16'h00c7);
		u_pvs_host.wr(8'h30, 16'h0000);
		rd_chk(CMD_SW_RATE, 16'h0aee);
		check({12'h0, fsw_index}, 16'h000b);
		check(alert_cnt, 16'h0004);
		// Converting: hardware must hold until the supply cycle
		@(negedge clk) conv_en = 1'b1;
		u_pvs_host.wr(CMD_LOOP_SCALE, 16'he004);
		u_pvs_host.wr(CMD_SW_RATE, 16'h0226);
		check({14'h0, divider_sel}, 16'h0002);
		check({12'h0, fsw_index}, 16'h000b);
		rd_chk(CMD_SW_RATE, 16'h0226);
		@(negedge clk) lockout_cycle = 1'b1;
		@(negedge clk) lockout_cycle = 1'b0;
		check({14'h0, divider_sel}, 16'h0001);
		check({12'h0, fsw_index}, 16'h0005);
		// Target below floor warns and ramps up to the floor
		@(negedge clk) status_clr = 1'b1;
		@(negedge clk) status_clr = 1'b0;
		u_pvs_host.wr(CMD_FLOOR_LIMIT, 16'h1000);
		rd_chk(CMD_FLOOR_LIMIT, 16'h1000);
		@(negedge clk) begin
			target_req = 1'b1;
			target_in  = 16'h0800;
		end
		@(negedge clk) target_req = 1'b0;
		for (int i = 0; i < 40 && vout_target !== 16'h1000; i++) @(negedge clk);
		check(vout_target, 16'h1000);
		check({status_word[15], status_byte[0], status_vout[6]}, 16'h0007);
		check(status_word, 16'h8001);
		check(alert_cnt, 16'h0005);
		@(negedge clk) status_clr = 1'b1;
		@(negedge clk) status_clr = 1'b0;
		check({15'h0, status_vout[6]}, 16'h0000);
		// Maximum below the present target
		@(negedge clk) begin
			max_wr = 1'b1;
			max_in = 16'h0800;
		end
		@(negedge clk) max_wr = 1'b0;
		@(negedge clk);
		check({15'h0, status_vout[6]}, 16'h0001);
		check(alert_cnt, 16'h0006);
		// Power-up restore with conversion off
		@(negedge clk) begin
			conv_en = 1'b0;
			restore = 1'b1;
		end
		@(negedge clk) restore = 1'b0;
		rd_chk(CMD_LOOP_SCALE, 16'he002);
		rd_chk(CMD_FLOOR_LIMIT, 16'h0200);
		rd_chk(CMD_SW_RATE, 16'h00e2);
		check({12'h0, fsw_index}, 16'h0000);
		check({14'h0, divider_sel}, 16'h0000);
		check(ref_scale, 16'h2000);
		end_sim;
	end
endmodule // pvs_regs_tb
